// *** hw/bms_regs.svh ***
`ifndef BMS_REGS_SVH
`define BMS_REGS_SVH

// register offsets on the plain register port
`define BMS_OFS_VOUT1     3'h1
`define BMS_OFS_VOUT2     3'h2
`define BMS_OFS_CTRL      3'h3
`define BMS_OFS_STATUS    3'h5
`define BMS_OFS_ADDR      3'h6
`define BMS_OFS_CODE      3'h7

// control register fields
`define BMS_CTRL_SWEN     0
`define BMS_CTRL_FFREQ    1
`define BMS_CTRL_DVSF     2
`define BMS_CTRL_DISCH    3
`define BMS_CTRL_RAMP_LO  4
`define BMS_CTRL_RAMP_HI  5
`define BMS_CTRL_SRST     7

// status register fields
`define BMS_STAT_LOCKOUT  0
`define BMS_STAT_TSD      1
`define BMS_STAT_RAMPING  2
`define BMS_STAT_PGOOD_N  3

// reset values
`define BMS_RST_VOUT2     8'h64
`define BMS_RST_RAMP      2'h0
`define BMS_RST_LEVEL     5'h10

// resistor level decode
`define BMS_LEVEL_GND     5'h10
`define BMS_CODE_TOP      8'h96
`define BMS_CODE_STEP     8'h0A
`define BMS_GND_CODE      8'h64

// timing
`define BMS_CLK_MHZ       100
`define BMS_T_START_US    650
`define BMS_T_DEGLITCH_US 34
`define BMS_T_GOOD_DLY_US 200
`define BMS_RAMP_BASE_CYC 250

`endif

// *** hw/bms_pkg.sv ***
package bms_pkg;

  typedef enum logic [2:0] {
    BMS_ST_OFF   = 3'b000,
    BMS_ST_WAIT  = 3'b001,
    BMS_ST_RAMP  = 3'b010,
    BMS_ST_RUN   = 3'b011,
    BMS_ST_HOLD  = 3'b100,
    BMS_ST_FAULT = 3'b101
  } bms_state_e;

  typedef struct packed {
    logic [1:0] ramp_speed;
    logic       scale_fixed;
    logic       force_ffreq;
    logic       sw_enable;
  } bms_ctrl_s;

endpackage

// *** hw/bms_res_decode.sv ***
`timescale 1ns/1ns
`include "bms_regs.svh"

module bms_res_decode #(
  parameter logic [7:0] GND_CODE = `BMS_GND_CODE
) (
  // resistor level, 0 = highest resistor, 16 = grounded
  input  wire logic [4:0] i_level,
  // decoded values
  output logic      [6:0] o_addr,
  output logic      [7:0] o_code
);

  always_comb begin
    o_code = `BMS_CODE_TOP - 8'(8'(i_level[3:0]) * `BMS_CODE_STEP);
    case (i_level)
      5'h00:   o_addr = 7'h46;
      5'h01:   o_addr = 7'h45;
      5'h02:   o_addr = 7'h44;
      5'h03:   o_addr = 7'h43;
      5'h04:   o_addr = 7'h42;
      5'h05:   o_addr = 7'h41;
      5'h06:   o_addr = 7'h48;
      5'h07:   o_addr = 7'h49;
      5'h08:   o_addr = 7'h4A;
      5'h09:   o_addr = 7'h4B;
      5'h0A:   o_addr = 7'h4C;
      5'h0B:   o_addr = 7'h4D;
      5'h0C:   o_addr = 7'h4E;
      5'h0D:   o_addr = 7'h4F;
      5'h0E:   o_addr = 7'h40;
      5'h0F:   o_addr = 7'h47;
      default: begin
        o_addr = 7'h46;
        o_code = GND_CODE;
      end
    endcase
  end

endmodule // bms_res_decode

// *** hw/bms_top.sv ***
// Our own choices: the plain strobed port and the address map.
`timescale 1ns/1ns
`include "bms_regs.svh"

module bms_top #(
  parameter bit         GOOD_VARIANT  = 1'b0,
  parameter bit         HW_EN_VARIANT = 1'b1,
  parameter int         START_CYC     = `BMS_T_START_US * `BMS_CLK_MHZ,
  parameter int         GOOD_DLY_CYC  = `BMS_T_GOOD_DLY_US * `BMS_CLK_MHZ,
  parameter int         RAMP_BASE_CYC = `BMS_RAMP_BASE_CYC,
  parameter logic [7:0] GND_CODE      = `BMS_GND_CODE
) (
  // clock and reset
  input  wire logic       i_ref_clk,
  input  wire logic       i_srst,
  // pins and analog status
  input  wire logic       i_chip_on,
  input  wire logic       i_voltage_bank_select,
  input  wire logic       i_low_input_lockout,
  input  wire logic       i_thermal_shutdown,
  input  wire logic       i_out_above_low,
  input  wire logic       i_out_below_high,
  // resistor code converter
  input  wire logic       i_res_valid,
  input  wire logic [4:0] i_res_level,
  output logic            o_res_source_on,
  // register port
  input  wire logic [2:0] i_reg_addr,
  input  wire logic [7:0] i_reg_wdata,
  input  wire logic       i_reg_wr,
  input  wire logic       i_reg_rd,
  output logic      [7:0] o_reg_rdata,
  // converter control
  output logic            o_switching_en,
  output logic            o_forced_fixed_frequency,
  output logic      [7:0] o_setpoint_code,
  output logic            o_discharge_on,
  output logic            o_output_in_window,
  output logic      [6:0] o_target_addr,
  output logic            o_serial_active
);

  localparam int DEGLITCH_CYC = `BMS_T_DEGLITCH_US * `BMS_CLK_MHZ;
  localparam int SCW = $clog2(START_CYC + 1);
  localparam int GCW = $clog2(GOOD_DLY_CYC + 1);
  localparam int DCW = $clog2(DEGLITCH_CYC + 1);
  localparam int RCW = $clog2(RAMP_BASE_CYC * 8 + 1);

  localparam logic [SCW-1:0] START_LAST = SCW'(START_CYC - 1);
  localparam logic [GCW-1:0] GOOD_LAST  = GCW'(GOOD_DLY_CYC - 1);
  localparam logic [DCW-1:0] DG_LAST    = DCW'(DEGLITCH_CYC - 1);
  localparam logic [RCW-1:0] RAMP_BASE  = RCW'(RAMP_BASE_CYC);

  localparam bms_pkg::bms_ctrl_s CTRL_RST = '{
    ramp_speed: `BMS_RST_RAMP,
    scale_fixed: 1'b0,
    force_ffreq: 1'b0,
    sw_enable:  HW_EN_VARIANT
  };

  bms_pkg::bms_state_e state_q;
  bms_pkg::bms_ctrl_s  ctrl_q;

  logic           chip_on_q;
  logic [SCW-1:0] wait_cnt_q;
  logic           res_done_q;
  logic [4:0]     level_q;
  logic [7:0]     vout1_q;
  logic [7:0]     vout2_q;
  logic           disch_q;
  logic [RCW-1:0] ramp_cnt_q;
  logic           reached_q;
  logic [GCW-1:0] good_cnt_q;
  logic           good_ok_q;
  logic           filt_bad_q;
  logic [DCW-1:0] dg_cnt_q;

  logic [6:0] dec_addr;
  logic [7:0] dec_code;
  logic [7:0] target;
  logic       shutdown;
  logic       fault;
  logic       chip_rise;
  logic       wr_ok;
  logic       ctrl_wr;
  logic       soft_rst;
  logic       reg_clr;
  logic       wait_end;
  logic       sw_toggle;
  logic       ramping;
  logic       active;
  logic       comparing;
  logic       raw_bad;
  logic       ramp_tick;
  logic       force_ff;
  logic [RCW-1:0] ramp_last;

  assign shutdown  = ~i_chip_on;
  assign fault     = i_low_input_lockout | i_thermal_shutdown;
  assign chip_rise = i_chip_on & ~chip_on_q;
  assign wr_ok     = i_reg_wr & o_serial_active & i_chip_on;
  assign ctrl_wr   = wr_ok & (i_reg_addr == `BMS_OFS_CTRL);
  assign soft_rst  = ctrl_wr & i_reg_wdata[`BMS_CTRL_SRST];
  assign reg_clr   = i_srst | shutdown | soft_rst;
  assign wait_end  = (state_q == bms_pkg::BMS_ST_WAIT) &&
                     (wait_cnt_q == START_LAST);
  assign sw_toggle = ctrl_wr & ~soft_rst &
                     (i_reg_wdata[`BMS_CTRL_SWEN] != ctrl_q.sw_enable);
  assign active    = (state_q == bms_pkg::BMS_ST_RAMP) ||
                     (state_q == bms_pkg::BMS_ST_RUN);
  assign comparing = active || (state_q == bms_pkg::BMS_ST_HOLD);
  assign ramping   = (o_setpoint_code != target);
  assign raw_bad   = ~(i_out_above_low & i_out_below_high);
  assign force_ff  = ctrl_q.force_ffreq ||
                     (ctrl_q.scale_fixed && ramping &&
                      state_q == bms_pkg::BMS_ST_RUN);

  // bank pin only counts once start-up is over
  assign target = (state_q == bms_pkg::BMS_ST_RUN && i_voltage_bank_select &&
                   !GOOD_VARIANT) ? vout2_q : vout1_q;

  bms_res_decode #(
    .GND_CODE (GND_CODE)
  ) u_decode (
    .i_level (level_q),
    .o_addr  (dec_addr),
    .o_code  (dec_code)
  );

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      chip_on_q <= 1'b0;
    end else begin
      chip_on_q <= i_chip_on;
    end
  end

  // sequencer
  always_ff @(posedge i_ref_clk) begin
    if (i_srst || shutdown) begin
      state_q <= bms_pkg::BMS_ST_OFF;
    end else if (soft_rst) begin
      state_q <= bms_pkg::BMS_ST_WAIT;
    end else begin
      case (state_q)
        bms_pkg::BMS_ST_OFF: begin
          state_q <= bms_pkg::BMS_ST_WAIT;
        end
        bms_pkg::BMS_ST_WAIT: begin
          if (wait_end) begin
            if (fault) begin
              state_q <= bms_pkg::BMS_ST_FAULT;
            end else if (ctrl_q.sw_enable) begin
              state_q <= bms_pkg::BMS_ST_RAMP;
            end else begin
              state_q <= bms_pkg::BMS_ST_HOLD;
            end
          end
        end
        bms_pkg::BMS_ST_FAULT: begin
          if (!fault) begin
            state_q <= ctrl_q.sw_enable ? bms_pkg::BMS_ST_RAMP
                                        : bms_pkg::BMS_ST_HOLD;
          end
        end
        bms_pkg::BMS_ST_RAMP, bms_pkg::BMS_ST_RUN, bms_pkg::BMS_ST_HOLD: begin
          if (fault) begin
            state_q <= bms_pkg::BMS_ST_FAULT;
          end else if (sw_toggle) begin
            state_q <= i_reg_wdata[`BMS_CTRL_SWEN] ? bms_pkg::BMS_ST_RAMP
                                                   : bms_pkg::BMS_ST_HOLD;
          end else if (state_q == bms_pkg::BMS_ST_RAMP && !ramping) begin
            state_q <= bms_pkg::BMS_ST_RUN;
          end
        end
        default: begin
          state_q <= bms_pkg::BMS_ST_OFF;
        end
      endcase
    end
  end

  // start-up wait
  always_ff @(posedge i_ref_clk) begin
    if (i_srst || state_q != bms_pkg::BMS_ST_WAIT || soft_rst) begin
      wait_cnt_q <= '0;
    end else if (!wait_end) begin
      wait_cnt_q <= wait_cnt_q + SCW'(1);
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      o_serial_active <= 1'b0;
    end else begin
      o_serial_active <= i_chip_on && !soft_rst &&
                         state_q != bms_pkg::BMS_ST_OFF &&
                         state_q != bms_pkg::BMS_ST_WAIT;
    end
  end

  // resistor conversion, once per enable
  always_ff @(posedge i_ref_clk) begin
    if (i_srst || state_q == bms_pkg::BMS_ST_OFF) begin
      res_done_q      <= 1'b0;
      level_q         <= `BMS_RST_LEVEL;
      o_res_source_on <= 1'b0;
    end else if (o_res_source_on && i_res_valid) begin
      res_done_q      <= 1'b1;
      level_q         <= i_res_level;
      o_res_source_on <= 1'b0;
    end else begin
      o_res_source_on <= (state_q == bms_pkg::BMS_ST_WAIT) && !res_done_q &&
                         !wait_end;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      o_target_addr <= 7'h46;
    end else begin
      o_target_addr <= dec_addr;
    end
  end

  // voltage registers
  always_ff @(posedge i_ref_clk) begin
    if (reg_clr || wait_end) begin
      vout1_q <= dec_code;
    end else if (wr_ok && i_reg_addr == `BMS_OFS_VOUT1) begin
      vout1_q <= i_reg_wdata;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (reg_clr) begin
      vout2_q <= `BMS_RST_VOUT2;
    end else if (wr_ok && i_reg_addr == `BMS_OFS_VOUT2 && !GOOD_VARIANT) begin
      vout2_q <= i_reg_wdata;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (reg_clr) begin
      ctrl_q <= CTRL_RST;
    end else if (ctrl_wr) begin
      ctrl_q.sw_enable   <= i_reg_wdata[`BMS_CTRL_SWEN];
      ctrl_q.force_ffreq <= i_reg_wdata[`BMS_CTRL_FFREQ];
      ctrl_q.scale_fixed <= i_reg_wdata[`BMS_CTRL_DVSF];
      ctrl_q.ramp_speed  <= i_reg_wdata[`BMS_CTRL_RAMP_HI:`BMS_CTRL_RAMP_LO];
    end
  end

  // discharge bit survives shutdown
  always_ff @(posedge i_ref_clk) begin
    if (i_srst || chip_rise) begin
      disch_q <= 1'b0;
    end else if (ctrl_wr && !soft_rst) begin
      disch_q <= i_reg_wdata[`BMS_CTRL_DISCH];
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      o_discharge_on <= 1'b0;
    end else begin
      o_discharge_on <= disch_q & (shutdown | fault);
    end
  end

  // ramp pacing
  assign ramp_last = RCW'(RAMP_BASE << ctrl_q.ramp_speed) - RCW'(1);
  assign ramp_tick = (ramp_cnt_q >= ramp_last);

  always_ff @(posedge i_ref_clk) begin
    if (i_srst || !active || ramp_tick) begin
      ramp_cnt_q <= '0;
    end else begin
      ramp_cnt_q <= ramp_cnt_q + RCW'(1);
    end
  end

  // setpoint restarts from zero on every fresh ramp
  always_ff @(posedge i_ref_clk) begin
    if (i_srst || shutdown || !active || sw_toggle) begin
      o_setpoint_code <= 8'h00;
    end else if (ramp_tick && ramping) begin
      if (o_setpoint_code < target) begin
        o_setpoint_code <= o_setpoint_code + 8'h01;
      end else if (force_ff) begin
        o_setpoint_code <= o_setpoint_code - 8'h01;
      end else begin
        o_setpoint_code <= target;
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      o_switching_en           <= 1'b0;
      o_forced_fixed_frequency <= 1'b0;
    end else begin
      o_switching_en           <= active && !shutdown && !fault &&
                                  !sw_toggle && !soft_rst;
      o_forced_fixed_frequency <= force_ff;
    end
  end

  // power-good start-up delay
  always_ff @(posedge i_ref_clk) begin
    if (i_srst || !comparing) begin
      reached_q  <= 1'b0;
      good_cnt_q <= '0;
      good_ok_q  <= 1'b0;
    end else begin
      if (state_q == bms_pkg::BMS_ST_RUN) begin
        reached_q <= 1'b1;
      end
      if (reached_q && !good_ok_q) begin
        if (good_cnt_q == GOOD_LAST) begin
          good_ok_q <= 1'b1;
        end else begin
          good_cnt_q <= good_cnt_q + GCW'(1);
        end
      end
    end
  end

  // power-good deglitch
  always_ff @(posedge i_ref_clk) begin
    if (i_srst || !comparing) begin
      filt_bad_q <= 1'b1;
      dg_cnt_q   <= '0;
    end else if (raw_bad == filt_bad_q) begin
      dg_cnt_q <= '0;
    end else if (dg_cnt_q == DG_LAST) begin
      filt_bad_q <= raw_bad;
      dg_cnt_q   <= '0;
    end else begin
      dg_cnt_q <= dg_cnt_q + DCW'(1);
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_srst || shutdown || fault || !comparing || !GOOD_VARIANT) begin
      o_output_in_window <= 1'b1;
    end else begin
      o_output_in_window <= filt_bad_q | ~good_ok_q;
    end
  end

  // register reads, data one cycle after the strobe
  always_ff @(posedge i_ref_clk) begin
    if (i_srst || !(i_reg_rd && o_serial_active && i_chip_on)) begin
      o_reg_rdata <= 8'h00;
    end else begin
      o_reg_rdata <= 8'h00;
      case (i_reg_addr)
        `BMS_OFS_VOUT1: begin
          o_reg_rdata <= vout1_q;
        end
        `BMS_OFS_VOUT2: begin
          o_reg_rdata <= GOOD_VARIANT ? 8'h00 : vout2_q;
        end
        `BMS_OFS_CTRL: begin
          o_reg_rdata[`BMS_CTRL_SWEN]  <= ctrl_q.sw_enable;
          o_reg_rdata[`BMS_CTRL_FFREQ] <= ctrl_q.force_ffreq;
          o_reg_rdata[`BMS_CTRL_DVSF]  <= ctrl_q.scale_fixed;
          o_reg_rdata[`BMS_CTRL_DISCH] <= disch_q;
          o_reg_rdata[`BMS_CTRL_RAMP_HI:`BMS_CTRL_RAMP_LO] <=
            ctrl_q.ramp_speed;
        end
        `BMS_OFS_STATUS: begin
          o_reg_rdata[`BMS_STAT_LOCKOUT] <= i_low_input_lockout;
          o_reg_rdata[`BMS_STAT_TSD]     <= i_thermal_shutdown;
          o_reg_rdata[`BMS_STAT_RAMPING] <= ramping;
          o_reg_rdata[`BMS_STAT_PGOOD_N] <= o_output_in_window;
        end
        `BMS_OFS_ADDR: begin
          o_reg_rdata <= {1'b0, o_target_addr};
        end
        `BMS_OFS_CODE: begin
          o_reg_rdata <= {3'b000, level_q};
        end
        default: begin
          o_reg_rdata <= 8'h00;
        end
      endcase
    end
  end

endmodule // bms_top

// *** dv/bms_res_model.sv ***
`timescale 1ns/1ns

module bms_res_model (
  // clock and reset
  input  wire logic       i_ref_clk,
  input  wire logic       i_srst,
  // setting from the bench
  input  wire logic [4:0] i_level,
  input  wire logic       i_slow,
  // converter face
  input  wire logic       i_source_on,
  output logic            o_valid,
  output logic      [4:0] o_level
);
  logic [3:0] cnt_q;

  // result only while the source runs; scrambled level otherwise
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      cnt_q   <= 4'h0;
      o_valid <= 1'b0;
      o_level <= 5'h0A;
    end else if (!i_source_on) begin
      cnt_q   <= 4'h0;
      o_valid <= 1'b0;
      o_level <= ~o_level;
    end else if (cnt_q == (i_slow ? 4'h6 : 4'h0)) begin
      o_valid <= 1'b1;
      o_level <= i_level;
    end else begin
      cnt_q <= cnt_q + 4'h1;
    end
  end
endmodule // bms_res_model

// *** dv/bms_top_checker.sv ***
`timescale 1ns/1ns

module bms_top_checker #(
  parameter int START_CYC = 20
) (
  // clock and reset
  input wire logic       i_ref_clk,
  input wire logic       i_srst,
  // pins and port inputs
  input wire logic       i_chip_on,
  input wire logic       i_low_input_lockout,
  input wire logic       i_thermal_shutdown,
  input wire logic       i_res_valid,
  input wire logic       i_reg_rd,
  // design outputs
  input wire logic       o_res_source_on,
  input wire logic [7:0] o_reg_rdata,
  input wire logic       o_switching_en,
  input wire logic [7:0] o_setpoint_code,
  input wire logic       o_discharge_on,
  input wire logic       o_output_in_window,
  input wire logic [6:0] o_target_addr,
  input wire logic       o_serial_active
);
  logic        cause_q;
  int unsigned on_cnt_q;

  always_ff @(posedge i_ref_clk) begin
    cause_q <= !i_chip_on || i_low_input_lockout || i_thermal_shutdown;
  end

  // cycles of chip-on high, saturating
  always_ff @(posedge i_ref_clk) begin
    if (i_srst || !i_chip_on) on_cnt_q <= 0;
    else if (on_cnt_q < START_CYC) on_cnt_q <= on_cnt_q + 1;
  end

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_srst);

  sequence s_on_run;
    o_serial_active && i_chip_on ##1 i_chip_on;
  endsequence

  sequence s_source_done;
    o_res_source_on && i_res_valid;
  endsequence

  a_shut_stop: assert property (!i_chip_on |=>
    !o_switching_en && o_setpoint_code == 8'h00) else $error("run in off");
  a_port_closed: assert property (!i_chip_on |=> !o_serial_active)
    else $error("port open in off");
  a_dead_read: assert property (i_reg_rd && !o_serial_active |=>
    o_reg_rdata == 8'h00) else $error("closed port read data");
  a_disch_cause: assert property (o_discharge_on |-> cause_q)
    else $error("discharge without cause");
  a_disch_clear: assert property ($rose(i_chip_on) |->
    ##[1:2] !o_discharge_on) else $error("discharge not cleared");
  a_source_off: assert property (s_source_done |=> !o_res_source_on)
    else $error("source left on");
  a_addr_held: assert property (s_on_run |-> $stable(o_target_addr))
    else $error("address moved");
  a_ramp_step: assert property ($past(o_switching_en) &&
    o_switching_en && o_setpoint_code > $past(o_setpoint_code) |->
    o_setpoint_code == $past(o_setpoint_code) + 8'h01)
    else $error("rise not one step");
  a_serial_wait: assert property ($rose(o_serial_active) |->
    on_cnt_q >= START_CYC) else $error("port opened early");
  a_pin_high_off: assert property ((!i_chip_on ||
    i_thermal_shutdown || i_low_input_lockout) |=> o_output_in_window)
    else $error("good pin low in off");
  a_rd_idle: assert property (!i_reg_rd |=> o_reg_rdata == 8'h00)
    else $error("read data stands");
endmodule // bms_top_checker

// *** dv/test_buck_mode_sequencer.sv ***
`timescale 1ns/1ns
`include "bms_regs.svh"

module test_buck_mode_sequencer;
  localparam logic [6:0] ATAB [0:16] = '{7'h46, 7'h45, 7'h44, 7'h43,
    7'h42, 7'h41, 7'h48, 7'h49, 7'h4A, 7'h4B, 7'h4C, 7'h4D, 7'h4E,
    7'h4F, 7'h40, 7'h47, 7'h46};
  logic       clk, srst, chip_on, bank, lockout, thermal, above, below;
  logic       res_valid, wr, rd, slow, source_on, sw_on, ffreq, disch;
  logic       win_n, alt_win_n, serial;
  logic [4:0] res_level, lvl;
  logic [2:0] addr;
  logic [7:0] wdata, rdata, sp, code;
  logic [6:0] taddr;
  int         fails, comparisons;

  bms_top #(.START_CYC(20), .GOOD_DLY_CYC(10), .RAMP_BASE_CYC(2)) u_dut (
    .i_ref_clk(clk), .i_srst(srst), .i_chip_on(chip_on),
    .i_voltage_bank_select(bank), .i_low_input_lockout(lockout),
    .i_thermal_shutdown(thermal), .i_out_above_low(above),
    .i_out_below_high(below), .i_res_valid(res_valid),
    .i_res_level(res_level), .o_res_source_on(source_on),
    .i_reg_addr(addr), .i_reg_wdata(wdata), .i_reg_wr(wr), .i_reg_rd(rd),
    .o_reg_rdata(rdata), .o_switching_en(sw_on),
    .o_forced_fixed_frequency(ffreq), .o_setpoint_code(sp),
    .o_discharge_on(disch), .o_output_in_window(win_n),
    .o_target_addr(taddr), .o_serial_active(serial));

  // power-good variant in lockstep, only its pin is watched
  bms_top #(.GOOD_VARIANT(1'b1), .START_CYC(20), .GOOD_DLY_CYC(10),
    .RAMP_BASE_CYC(2)) u_dut_alt (
    .i_ref_clk(clk), .i_srst(srst), .i_chip_on(chip_on),
    .i_voltage_bank_select(bank), .i_low_input_lockout(lockout),
    .i_thermal_shutdown(thermal), .i_out_above_low(above),
    .i_out_below_high(below), .i_res_valid(res_valid),
    .i_res_level(res_level), .o_res_source_on(), .i_reg_addr(addr),
    .i_reg_wdata(wdata), .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(),
    .o_switching_en(), .o_forced_fixed_frequency(), .o_setpoint_code(),
    .o_discharge_on(), .o_output_in_window(alt_win_n),
    .o_target_addr(), .o_serial_active());

  bms_res_model u_res (.i_ref_clk(clk), .i_srst(srst), .i_level(lvl),
    .i_slow(slow), .i_source_on(source_on), .o_valid(res_valid),
    .o_level(res_level));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic finish_test();
    $display("comparisons %0d, mismatches %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic wait_val(input bit use_sp, input logic [7:0] exp);
    for (int n = 0; n < 2000; n++) begin
      if ((use_sp ? sp : {7'h00, serial}) === exp) return;
      @(posedge clk);
      #1;
    end
    fails++;
    finish_test();
  endtask

  task automatic reg_wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_chk(input logic [2:0] a, input logic [7:0] exp);
    @(posedge clk);
    rd   <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 check(rdata, exp);
  endtask

  task automatic restart(input logic [4:0] l);
    @(posedge clk);
    lvl     <= l;
    slow    <= l[0];
    chip_on <= 1'b0;
    repeat (3) @(posedge clk);
    chip_on <= 1'b1;
    #1 wait_val(1'b0, 8'h01);
  endtask

  initial begin
    {srst, chip_on, above, below} = 4'hF;
    {bank, lockout, thermal, wr, rd, slow} = 6'h00;
    addr  = 3'h0;
    wdata = 8'h00;
    lvl   = 5'h05;
    fails = 0;
    comparisons = 0;
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    #1 wait_val(1'b0, 8'h01);
    rd_chk(`BMS_OFS_CTRL, 8'h01);
    rd_chk(`BMS_OFS_VOUT2, `BMS_RST_VOUT2);
    rd_chk(3'h0, 8'h00);
    rd_chk(3'h4, 8'h00);
    $display("test defaults done");
    for (int l = 0; l <= 16; l++) begin
      code = (l == 16) ? `BMS_GND_CODE
                       : 8'(`BMS_CODE_TOP - l * `BMS_CODE_STEP);
      restart(5'(l));
      check({1'b0, taddr}, {1'b0, ATAB[l]});
      check({7'h00, source_on}, 8'h00);
      rd_chk(`BMS_OFS_ADDR, {1'b0, ATAB[l]});
      rd_chk(`BMS_OFS_CODE, 8'(l));
      rd_chk(`BMS_OFS_VOUT1, code);
      wait_val(1'b1, code);
    end
    $display("test resistor decode done");
    reg_wr(`BMS_OFS_VOUT2, 8'h70);
    @(posedge clk);
    bank <= 1'b1;
    #1 wait_val(1'b1, 8'h70);
    @(posedge clk);
    bank <= 1'b0;
    repeat (4) @(posedge clk);
    #1 check(sp, 8'h64);
    reg_wr(`BMS_OFS_CTRL, 8'h05);
    @(posedge clk);
    bank <= 1'b1;
    repeat (3) @(posedge clk);
    #1 check({7'h00, ffreq}, 8'h01);
    wait_val(1'b1, 8'h70);
    repeat (3) @(posedge clk);
    #1 check({7'h00, ffreq}, 8'h00);
    @(posedge clk);
    bank <= 1'b0;
    repeat (6) @(posedge clk);
    #1 check({7'h00, sp > 8'h64}, 8'h01);
    wait_val(1'b1, 8'h64);
    $display("test bank and ramp done");
    reg_wr(`BMS_OFS_CTRL, 8'h04);
    repeat (2) @(posedge clk);
    #1 check({6'h00, serial, sw_on}, 8'h02);
    rd_chk(`BMS_OFS_VOUT2, 8'h70);
    reg_wr(`BMS_OFS_CTRL, 8'h05);
    repeat (2) @(posedge clk);
    #1 check({6'h00, sw_on, sp < 8'h10}, 8'h03);
    wait_val(1'b1, 8'h64);
    $display("test software enable done");
    reg_wr(`BMS_OFS_CTRL, 8'h0D);
    @(posedge clk);
    lockout <= 1'b1;
    repeat (3) @(posedge clk);
    #1 check({7'h00, disch}, 8'h01);
    @(posedge clk);
    lockout <= 1'b0;
    thermal <= 1'b1;
    repeat (3) @(posedge clk);
    #1 check({6'h00, disch, sw_on}, 8'h02);
    @(posedge clk);
    thermal <= 1'b0;
    repeat (3) @(posedge clk);
    #1 check({7'h00, disch}, 8'h00);
    @(posedge clk);
    chip_on <= 1'b0;
    repeat (3) @(posedge clk);
    #1 check({3'h0, alt_win_n, win_n, disch, sw_on, serial},
             8'h1C);
    reg_wr(`BMS_OFS_VOUT2, 8'h22);
    rd_chk(`BMS_OFS_CTRL, 8'h00);
    #1 check({7'h00, disch}, 8'h01);
    @(posedge clk);
    chip_on <= 1'b1;
    repeat (2) @(posedge clk);
    #1 check({7'h00, disch}, 8'h00);
    wait_val(1'b0, 8'h01);
    rd_chk(`BMS_OFS_CTRL, 8'h01);
    rd_chk(`BMS_OFS_VOUT2, `BMS_RST_VOUT2);
    $display("test shutdown and discharge done");
    reg_wr(`BMS_OFS_CTRL, 8'h09);
    reg_wr(`BMS_OFS_CTRL, 8'h80);
    repeat (2) @(posedge clk);
    #1 check({7'h00, serial}, 8'h00);
    wait_val(1'b0, 8'h01);
    rd_chk(`BMS_OFS_CTRL, 8'h09);
    wait_val(1'b1, `BMS_GND_CODE);
    repeat (3500) @(posedge clk);
    #1 check({7'h00, alt_win_n}, 8'h00);
    @(posedge clk);
    above <= 1'b0;
    repeat (3300) @(posedge clk);
    #1 check({7'h00, alt_win_n}, 8'h00);
    repeat (200) @(posedge clk);
    #1 check({7'h00, alt_win_n}, 8'h01);
    $display("test soft reset and good pin done");
    finish_test();
  end
endmodule // test_buck_mode_sequencer

bind bms_top bms_top_checker #(.START_CYC(START_CYC)) u_chk (
  .i_ref_clk(i_ref_clk), .i_srst(i_srst), .i_chip_on(i_chip_on),
  .i_low_input_lockout(i_low_input_lockout),
  .i_thermal_shutdown(i_thermal_shutdown), .i_res_valid(i_res_valid),
  .i_reg_rd(i_reg_rd), .o_res_source_on(o_res_source_on),
  .o_reg_rdata(o_reg_rdata), .o_switching_en(o_switching_en),
  .o_setpoint_code(o_setpoint_code), .o_discharge_on(o_discharge_on),
  .o_output_in_window(o_output_in_window),
  .o_target_addr(o_target_addr), .o_serial_active(o_serial_active));
